// [logic/ase_core.sv]
// skip evaluation and rotate datapath of a 4-bit core alu
// assumes the sequencer, data memory and axi master run on mclk;
// memory read data is valid the cycle after rd_en is seen high
// one instruction in flight; the sequencer waits for done before the next
// mem_rd_data is used unregistered, so it must come from an mclk flop
//
// How it works
// - all-set test skips when every masked memory bit is one
// - all-clear test skips when every masked memory bit is zero
// - bit tests read data memory only; mask is the immediate
// - bit tests ignore decimal mode, keep carry and zero
// - either bit test clears the compare-only flag
// - index enable set: memory address is modified by index first
// - equal compare skips when memory equals immediate
// - unequal compare skips when memory differs from immediate
// - at-least compare skips when memory >= immediate
// - below compare skips when memory < immediate
// - compares take memory against immediate
// - compares ignore decimal and compare-only, keep carry and zero
// - rotate takes a general register and writes it back there
// - rotate ignores decimal and compare-only, keeps zero
// - rotate: carry to bit 3, bits shift down, bit 0 to carry
// - add with carry sums a register, a memory operand and carry, top bit to carry
// - a requested skip makes the next instruction a no-operation
// - operands are staged in temp a and temp b before the alu acts
`timescale 1ns/1ps
`default_nettype none

module ase_core
	import ase_pkg::*;
(
	// clock and reset
	input  wire logic                 mclk,
	input  wire logic                 rst,
	// sequencer
	input  wire logic                 req_valid,
	input  wire ase_req_t             req,
	output logic                      req_ready,
	output logic                      done,
	output logic                      skip,
	// data memory and general register
	output ase_mem_t                  mem,
	input  wire logic [3:0]           mem_rd_data,
	// axi4-lite slave
	input  wire logic [AXI_AW-1:0]    s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [AXI_AW-1:0]    s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// operand address of a memory access, index applied when enabled
	function automatic logic [ADDR_W-1:0] mem_operand(
		input logic [ADDR_W-1:0] base,
		input logic [ADDR_W-1:0] idx,
		input logic              index_enable_flag
	);
		// or-ing instead of adding keeps the address inside the 7-bit space
		mem_operand = index_enable_flag ? (base | idx) : base;
	endfunction : mem_operand

	// skip decision for every evaluation op; a = memory, b = immediate
	function automatic logic eval_skip(
		input ase_op_t    op,
		input logic [3:0] a,
		input logic [3:0] b
	);
		// a zero mask selects no bit, so either bit test then skips
		case (op)
			skip_if_all_set_op:   eval_skip = ((a & b) == b);
			skip_if_all_clear_op: eval_skip = ((a & b) == 4'h0);
			skip_if_equal_op:     eval_skip = (a == b);
			skip_if_unequal_op:   eval_skip = (a != b);
			skip_if_not_below_op: eval_skip = (a >= b);
			skip_if_below_op:     eval_skip = (a < b);
			default:              eval_skip = 1'b0;
		endcase
	endfunction : eval_skip

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	ase_regs_t r;
	ase_regs_t next_r;

	logic [4:0]  sum;
	logic [3:0]  rot;

	always_comb begin
		next_r = r;
		sum    = {1'b0, r.tmp_a} + {1'b0, r.tmp_b} + {4'h0, r.flags[CARRY_BIT]};
		rot    = {r.flags[CARRY_BIT], r.tmp_a[3:1]};
		next_r.done       = 1'b0;
		next_r.skip       = 1'b0;
		next_r.mem.rd_en  = 1'b0;
		next_r.mem.wr_en  = 1'b0;

		// ------------------------------------------------------------
		// axi4-lite write: address and data taken in either order
		// ------------------------------------------------------------
		if (r.awready && s_axi_awvalid) begin
			next_r.aw_got = 1'b1;
			next_r.awaddr = s_axi_awaddr;
		end
		if (r.wready && s_axi_wvalid) begin
			next_r.w_got = 1'b1;
			next_r.wdata = s_axi_wdata;
			next_r.wstrb = s_axi_wstrb;
		end
		if (r.bvalid && s_axi_bready) begin
			next_r.bvalid = 1'b0;
		end
		// a pending response stalls both channels: one write in flight
		if (r.aw_got && r.w_got && !r.bvalid) begin
			next_r.aw_got = 1'b0;
			next_r.w_got  = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp  = RESP_OKAY;
			// only the low byte holds anything; upper lanes are ignored
			if (r.awaddr == FLAGS_OFF) begin
				if (r.wstrb[0]) begin
					next_r.flags = r.wdata[4:0];
				end
			end else if (r.awaddr == INDEX_OFF) begin
				if (r.wstrb[0]) begin
					next_r.index = r.wdata[ADDR_W-1:0];
				end
			end else if (r.awaddr == STATUS_OFF) begin
				next_r.bresp = RESP_OKAY;
			end else begin
				next_r.bresp = RESP_SLVERR;
			end
		end
		next_r.awready = !next_r.aw_got && !next_r.bvalid;
		next_r.wready  = !next_r.w_got && !next_r.bvalid;

		// ------------------------------------------------------------
		// axi4-lite read
		// ------------------------------------------------------------
		if (r.rvalid && s_axi_rready) begin
			next_r.rvalid = 1'b0;
		end
		// read data is a snapshot taken at the address handshake
		if (r.arready && s_axi_arvalid) begin
			next_r.rvalid = 1'b1;
			next_r.rresp  = RESP_OKAY;
			next_r.rdata  = 32'h0000_0000;
			if (s_axi_araddr == FLAGS_OFF) begin
				next_r.rdata[4:0] = r.flags;
			end else if (s_axi_araddr == INDEX_OFF) begin
				next_r.rdata[ADDR_W-1:0] = r.index;
			end else if (s_axi_araddr == STATUS_OFF) begin
				next_r.rdata[BUSY_BIT]              = (r.st != st_idle);
				next_r.rdata[SKIP_BIT]              = r.last_skip;
				next_r.rdata[TMPA_LSB +: 4]         = r.tmp_a;
				next_r.rdata[TMPB_LSB +: 4]         = r.tmp_b;
			end else begin
				next_r.rresp = RESP_SLVERR;
			end
		end
		next_r.arready = !next_r.rvalid;

		// ------------------------------------------------------------
		// operand staging and execution; runs after the bus so that a
		// flag update by an instruction wins over a software write
		// ------------------------------------------------------------
		case (r.st)
			st_idle: begin
				next_r.req_ready = 1'b1;
				if (r.req_ready && req_valid) begin
					next_r.req_ready = 1'b0;
					next_r.req       = req;
					next_r.mem.rd_en = 1'b1;
					next_r.st        = st_wait_a;
					// register operands share the port but are never indexed
					if (req.op == rotate_right_carry_op || req.op == add_with_carry_op) begin
						next_r.mem.addr = req.reg_addr;
					end else begin
						next_r.mem.addr = mem_operand(req.mem_addr, r.index, r.flags[IXE_BIT]);
					end
				end
			end
			st_wait_a: begin
				// memory answers one cycle after the strobe
				next_r.st = st_load_a;
			end
			st_load_a: begin
				next_r.tmp_a = mem_rd_data;
				if (r.req.op == add_with_carry_op) begin
					next_r.mem.rd_en = 1'b1;
					next_r.mem.addr  = mem_operand(r.req.mem_addr, r.index, r.flags[IXE_BIT]);
					next_r.st        = st_wait_b;
				end else begin
					next_r.tmp_b = r.req.imm;
					next_r.st    = st_exec;
				end
			end
			st_wait_b: begin
				// second operand read, same one-cycle memory latency
				next_r.st = st_load_b;
			end
			st_load_b: begin
				next_r.tmp_b = mem_rd_data;
				next_r.st    = st_exec;
			end
			st_exec: begin
				// done and skip are one-cycle pulses; the sequencer sees them the cycle after exec
				next_r.done      = 1'b1;
				next_r.st        = st_idle;
				next_r.req_ready = 1'b1;
				case (r.req.op)
					rotate_right_carry_op: begin
						// zero flag and decimal/compare-only untouched
						next_r.mem.wr_en            = 1'b1;
						next_r.mem.addr             = r.req.reg_addr;
						next_r.mem.wr_data          = rot;
						next_r.flags[CARRY_BIT]     = r.tmp_a[0];
						next_r.last_skip            = 1'b0;
					end
					add_with_carry_op: begin
						// r + r + carry is the left-rotate building block
						next_r.flags[CARRY_BIT] = sum[4];
						if (r.flags[CMP_BIT]) begin
							// compare-only: result dropped, zero only ever cleared
							next_r.flags[ZERO_BIT] = r.flags[ZERO_BIT] & (sum[3:0] == 4'h0);
						end else begin
							next_r.flags[ZERO_BIT] = (sum[3:0] == 4'h0);
							next_r.mem.wr_en       = 1'b1;
							next_r.mem.addr        = r.req.reg_addr;
							next_r.mem.wr_data     = sum[3:0];
						end
						next_r.last_skip = 1'b0;
					end
					skip_if_all_set_op, skip_if_all_clear_op: begin
						// carry, zero and decimal left alone
						next_r.flags[CMP_BIT] = 1'b0;
						next_r.skip           = eval_skip(r.req.op, r.tmp_a, r.tmp_b);
						next_r.last_skip      = eval_skip(r.req.op, r.tmp_a, r.tmp_b);
					end
					default: begin
						// flags untouched by compares
						next_r.skip      = eval_skip(r.req.op, r.tmp_a, r.tmp_b);
						next_r.last_skip = eval_skip(r.req.op, r.tmp_a, r.tmp_b);
					end
				endcase
			end
			default: begin
				next_r.st = st_idle;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// reset drops a half-done instruction; no done is given for it
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			r       <= '0;
			r.st    <= st_idle;
			r.flags <= FLAGS_RST;
			r.index <= INDEX_RST;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from the state register
	// ----------------------------------------------------------------
	assign req_ready     = r.req_ready;
	assign done          = r.done;
	assign skip          = r.skip;
	// addr and wr_data hold between strobes; only the enables pulse
	assign mem           = r.mem;
	assign s_axi_awready = r.awready;
	assign s_axi_wready  = r.wready;
	assign s_axi_bresp   = r.bresp;
	assign s_axi_bvalid  = r.bvalid;
	assign s_axi_arready = r.arready;
	assign s_axi_rdata   = r.rdata;
	assign s_axi_rresp   = r.rresp;
	assign s_axi_rvalid  = r.rvalid;

endmodule : ase_core

`default_nettype wire

// [logic/ase_pkg.sv]
// skip evaluation and rotate datapath: shared types and constants
// assumes one core clock; every client sits on that same clock
package ase_pkg;

	// ----------------------------------------------------------------
	// widths and register map
	// ----------------------------------------------------------------
	localparam int          ADDR_W       = 7;
	localparam int          AXI_AW       = 8;
	localparam logic [7:0]  FLAGS_OFF    = 8'h00;
	localparam logic [7:0]  INDEX_OFF    = 8'h04;
	localparam logic [7:0]  STATUS_OFF   = 8'h08;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	// ----------------------------------------------------------------
	// bit positions in the flags and status words
	// ----------------------------------------------------------------
	localparam int          CARRY_BIT    = 0;
	localparam int          ZERO_BIT     = 1;
	localparam int          CMP_BIT      = 2;
	localparam int          BCD_BIT      = 3;
	localparam int          IXE_BIT      = 4;
	localparam int          BUSY_BIT     = 0;
	localparam int          SKIP_BIT     = 1;
	localparam int          TMPA_LSB     = 4;
	localparam int          TMPB_LSB     = 8;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [4:0]        FLAGS_RST = 5'h00;
	localparam logic [ADDR_W-1:0] INDEX_RST = 7'h00;

	typedef enum logic [2:0] {
		skip_if_all_set_op,
		skip_if_all_clear_op,
		skip_if_equal_op,
		skip_if_unequal_op,
		skip_if_not_below_op,
		skip_if_below_op,
		rotate_right_carry_op,
		add_with_carry_op
	} ase_op_t;

	typedef enum logic [2:0] {
		st_idle,
		st_wait_a,
		st_load_a,
		st_wait_b,
		st_load_b,
		st_exec
	} ase_state_t;

	// instruction from the sequencer
	typedef struct packed {
		ase_op_t             op;
		logic [ADDR_W-1:0]   mem_addr;
		logic [ADDR_W-1:0]   reg_addr;
		logic [3:0]          imm;
	} ase_req_t;

	// data memory / general register port
	typedef struct packed {
		logic                rd_en;
		logic                wr_en;
		logic [ADDR_W-1:0]   addr;
		logic [3:0]          wr_data;
	} ase_mem_t;

	typedef struct packed {
		ase_state_t          st;
		ase_req_t            req;
		logic [3:0]          tmp_a;
		logic [3:0]          tmp_b;
		logic [4:0]          flags;
		logic [ADDR_W-1:0]   index;
		ase_mem_t            mem;
		logic                req_ready;
		logic                done;
		logic                skip;
		logic                last_skip;
		logic                aw_got;
		logic                w_got;
		logic [AXI_AW-1:0]   awaddr;
		logic [31:0]         wdata;
		logic [3:0]          wstrb;
		logic                awready;
		logic                wready;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                arready;
		logic                rvalid;
		logic [31:0]         rdata;
		logic [1:0]          rresp;
	} ase_regs_t;

endpackage : ase_pkg

// [testbench/ase_core_monitor.sv]
// checker for the skip and rotate datapath, sees the core ports only
// assumes memory read data arrives the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module ase_core_monitor
	import ase_pkg::*;
(
	// clock and reset
	input wire logic       mclk,
	input wire logic       rst,
	// sequencer and memory
	input wire logic       req_valid,
	input wire ase_req_t   req,
	input wire logic       req_ready,
	input wire logic       done,
	input wire logic       skip,
	input wire ase_mem_t   mem,
	input wire logic [3:0] mem_rd_data,
	// read channel
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic       take;
	logic       rd_d;
	logic [3:0] dat;
	ase_req_t   cr;
	assign take = req_valid && req_ready;
	function automatic logic want(input ase_op_t o, input logic [3:0] d, input logic [3:0] m);
		logic [5:0] v;
		v = {d < m, d >= m, d != m, d == m, (d & m) == 4'h0, (d & m) == m};
		return v[o];
	endfunction : want
	// keeps the taken request and the last operand read to recompute the outcome
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rd_d <= 1'b0;
			dat  <= 4'h0;
			cr   <= '0;
		end else begin
			rd_d <= mem.rd_en;
			if (rd_d)
				dat <= mem_rd_data;
			if (take)
				cr <= req;
		end
	end
	AST_EVAL_LAT:
		assert property (take && req.op != add_with_carry_op |=> (!req_ready)[*3] ##1 (done && req_ready))
		else $error("eval or rotate did not finish in four cycles");
	AST_ADD_LAT:
		assert property (take && req.op == add_with_carry_op |-> ##6 done)
		else $error("add did not finish in six cycles");
	AST_BIT_SKIP:
		assert property (done && cr.op <= skip_if_all_clear_op |-> skip == want(cr.op, dat, cr.imm))
		else $error("bit test skip wrong");
	AST_CMP_SKIP:
		assert property (done && cr.op >= skip_if_equal_op && cr.op <= skip_if_below_op
			|-> skip == want(cr.op, dat, cr.imm))
		else $error("compare skip wrong");
	AST_ROT_READ:
		assert property (take && req.op == rotate_right_carry_op
			|=> mem.rd_en && mem.addr == $past(req.reg_addr))
		else $error("rotate did not read its register");
	AST_ROT_WRITE:
		assert property (done && cr.op == rotate_right_carry_op
			|-> mem.wr_en && mem.addr == cr.reg_addr && mem.wr_data[2:0] == dat[3:1])
		else $error("rotate write back wrong");
	AST_EVAL_NO_WR:
		assert property (done && cr.op <= skip_if_below_op |-> !mem.wr_en)
		else $error("evaluation wrote memory");
	AST_SKIP_DONE:
		assert property (skip |-> done)
		else $error("skip without done");
	AST_RD_ANSWER:
		assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	cover property (done && skip);
	cover property (take && req.op == rotate_right_carry_op);
	cover property (take && req.op == add_with_carry_op);
endmodule : ase_core_monitor
bind ase_core ase_core_monitor ase_core_monitor_i (.mclk(mclk), .rst(rst),
	.req_valid(req_valid), .req(req), .req_ready(req_ready), .done(done), .skip(skip),
	.mem(mem), .mem_rd_data(mem_rd_data), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));
`default_nettype wire

// [testbench/ase_mem_model.sv]
// data memory and general register model on the shared port
// assumes one read strobe gets data in exactly the following cycle
`timescale 1ns/1ps
`default_nettype none
module ase_mem_model
	import ase_pkg::*;
(
	// clock, reset and port
	input  wire logic     mclk,
	input  wire logic     rst,
	input  wire ase_mem_t mem,
	output logic [3:0]    mem_rd_data
);
	logic [3:0] ram [0:127];
	// data toggles outside the valid cycle so a late sample is caught
	always @(posedge mclk or posedge rst) begin
		if (rst)
			mem_rd_data <= 4'h0;
		else
			mem_rd_data <= mem.rd_en ? ram[mem.addr] : ~mem_rd_data;
		if (!rst && mem.wr_en)
			ram[mem.addr] <= mem.wr_data;
	end
endmodule : ase_mem_model
`default_nettype wire

// [testbench/tb.sv]
// self-checking bench for the skip and rotate datapath
// assumes the memory model and the monitor bind compile alongside
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ase_pkg::*;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        req_valid = 1'b0;
	ase_req_t    req = '0;
	logic        req_ready, done, skip, awready, wready, bvalid, arready, rvalid;
	ase_mem_t    mem;
	logic [3:0]  rdat, d, m;
	logic [6:0]  a;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [1:0]  bresp, rresp;
	int          fail_count = 0, n_tests = 0;
	logic        exp_q[$];
	ase_op_t     op;
	always #4 mclk = ~mclk;
	ase_core ase_core_i (.mclk(mclk), .rst(rst), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .done(done), .skip(skip), .mem(mem), .mem_rd_data(rdat),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	ase_mem_model ase_mem_model_i (.mclk(mclk), .rst(rst), .mem(mem), .mem_rd_data(rdat));
	function automatic logic want(input ase_op_t o, input logic [3:0] dv, input logic [3:0] mv);
		logic [5:0] v;
		v = {dv < mv, dv >= mv, dv != mv, dv == mv, (dv & mv) == 4'h0, (dv & mv) == mv};
		return v[o];
	endfunction : want
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task wrap_up;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up
	task wr(input logic [7:0] ad, input logic [31:0] v, input logic [1:0] er);
		logic pa, pw;
		@(posedge mclk);
		awaddr <= ad;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		while (pa || pw) begin
			@(posedge mclk);
			if (pa && awready === 1'b1) begin
				pa = 1'b0;
				awvalid <= 1'b0;
			end
			if (pw && wready === 1'b1) begin
				pw = 1'b0;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge mclk);
		check("bresp", bresp, er);
		bready <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] ad, input logic [31:0] ev, input logic [1:0] er);
		@(posedge mclk);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge mclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge mclk);
		check("rresp", rresp, er);
		if (er == RESP_OKAY)
			check("rdata", rdata, ev);
		rready <= 1'b0;
	endtask : rd
	// the expected skip is queued here and compared when done shows
	task run(input ase_op_t o, input logic [6:0] ma, input logic [6:0] ra, input logic [3:0] im,
		input logic es);
		@(posedge mclk);
		req_valid <= 1'b1;
		req <= '{o, ma, ra, im};
		exp_q.push_back(es);
		do @(posedge mclk); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		do @(posedge mclk); while (done !== 1'b1);
	endtask : run
	always @(posedge mclk) begin
		if (done === 1'b1 && exp_q.size() > 0)
			check("skip", skip, exp_q.pop_front());
		else if (done === 1'b1)
			check("stray done", 32'h1, 32'h0);
	end
	initial begin
		#100000;
		fail_count++;
		wrap_up();
	end
	initial begin
		void'($urandom(32'he5aa));
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		rd(FLAGS_OFF, 32'h0, RESP_OKAY);
		rd(INDEX_OFF, 32'h0, RESP_OKAY);
		for (int i = 0; i < 60; i++) begin
			op = ase_op_t'($urandom_range(5, 0));
			d = 4'($urandom);
			m = 4'($urandom);
			a = 7'($urandom);
			ase_mem_model_i.ram[a] = d;
			run(op, a, 7'h00, m, want(op, d, m));
		end
		wr(FLAGS_OFF, 32'h0f, RESP_OKAY);
		ase_mem_model_i.ram[7'h11] = 4'h4;
		run(skip_if_all_clear_op, 7'h11, 7'h00, 4'hb, 1'b1);
		rd(FLAGS_OFF, 32'h0b, RESP_OKAY);
		wr(FLAGS_OFF, 32'h0f, RESP_OKAY);
		run(skip_if_not_below_op, 7'h11, 7'h00, 4'h5, 1'b0);
		rd(FLAGS_OFF, 32'h0f, RESP_OKAY);
		ase_mem_model_i.ram[7'h22] = 4'hc;
		run(rotate_right_carry_op, 7'h00, 7'h22, 4'h0, 1'b0);
		rd(FLAGS_OFF, 32'h0e, RESP_OKAY);
		check("rotated", 32'(ase_mem_model_i.ram[7'h22]), 32'he);
		wr(FLAGS_OFF, 32'h01, RESP_OKAY);
		ase_mem_model_i.ram[7'h33] = 4'h9;
		run(add_with_carry_op, 7'h33, 7'h33, 4'h0, 1'b0);
		rd(FLAGS_OFF, 32'h01, RESP_OKAY);
		check("doubled", 32'(ase_mem_model_i.ram[7'h33]), 32'h3);
		wr(FLAGS_OFF, 32'h06, RESP_OKAY);
		ase_mem_model_i.ram[7'h44] = 4'h8;
		run(add_with_carry_op, 7'h44, 7'h44, 4'h0, 1'b0);
		rd(FLAGS_OFF, 32'h07, RESP_OKAY);
		check("kept", 32'(ase_mem_model_i.ram[7'h44]), 32'h8);
		wr(INDEX_OFF, 32'h10, RESP_OKAY);
		wr(FLAGS_OFF, 32'h10, RESP_OKAY);
		ase_mem_model_i.ram[7'h05] = 4'h0;
		ase_mem_model_i.ram[7'h15] = 4'h7;
		run(skip_if_equal_op, 7'h05, 7'h00, 4'h7, 1'b1);
		rd(STATUS_OFF, 32'h772, RESP_OKAY);
		rd(INDEX_OFF, 32'h10, RESP_OKAY);
		@(posedge mclk);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		rd(FLAGS_OFF, 32'h0, RESP_OKAY);
		rd(INDEX_OFF, 32'h0, RESP_OKAY);
		rd(STATUS_OFF, 32'h0, RESP_OKAY);
		rd(8'h0c, 32'h0, RESP_SLVERR);
		wr(8'h0c, 32'h1, RESP_SLVERR);
		wr(STATUS_OFF, 32'h3, RESP_OKAY);
		check("pending", 32'(exp_q.size()), 32'h0);
		wrap_up();
	end
endmodule : tb
`default_nettype wire
